// *** rtl/fdb_pkg.sv ***
/*
 * Shared constants for the fieldbus data-block and command-port logic:
 * command codes, command-area field positions, block geometry and reset values.
 * Assumes a single clock domain and a 16-byte command area presented
 * by logic on that clock.
 */
package fdb_pkg;

    // Block kinds carried per data block.
    typedef enum logic [1:0] {
        FDB_KIND_LEVSP,
        FDB_KIND_AO12,
        FDB_KIND_AO34
    } fdb_kind_e;

    typedef enum logic {
        FDB_WR_IDLE,
        FDB_WR_SEND
    } fdb_wr_state_e;

    localparam logic [7:0]  FDB_CMD_NONE     = 8'h00;
    localparam logic [7:0]  FDB_CMD_WINDOW   = 8'hFA;
    localparam logic [7:0]  FDB_CMD_WRITE    = 8'hFB;
    localparam logic [7:0]  FDB_CMD_CLR_RST  = 8'hFC;

    // Command area field positions, byte 0 in the top bits.
    localparam int          FDB_AREA_BITS    = 128;
    localparam int          FDB_CMD_MSB      = 127;
    localparam int          FDB_CNT_MSB      = 119;
    localparam int          FDB_ADDR_MSB     = 111;
    localparam int          FDB_DATA_MSB     = 95;
    localparam int          FDB_DATA_BITS    = 96;

    localparam int          FDB_BLK_BITS     = 128;
    localparam int          FDB_NUM_BLOCKS   = 12;
    localparam int          FDB_REG_BITS     = 16;
    localparam logic [7:0]  FDB_MAX_WR_REGS  = 8'h06;
    localparam logic [4:0]  FDB_WIN_REGS     = 5'h0C;

    localparam logic [15:0] FDB_RST_ADDR     = 16'h0000;
    localparam logic [7:0]  FDB_RST_CMD      = 8'h00;

endpackage

// *** rtl/fdb_blk_pack.sv ***
/*
 * Packs one 16-byte cyclic data block from live instrument values,
 * most significant byte first, in the layout chosen by kind and format.
 * Assumes the caller registers the result.
 */
`timescale 1ns/1ps
module fdb_blk_pack import fdb_pkg::*; (
    // Block selection
    input  wire fdb_kind_e    kind,
    input  wire logic         is_float,
    // Live values
    input  wire logic [31:0]  level_flags,
    input  wire logic [15:0]  setp_flags,
    input  wire logic [127:0] analog_output_flt,
    input  wire logic [127:0] analog_output_int,
    input  wire logic [63:0]  analog_output_dec,
    // Packed block
    output logic      [127:0] blk
);

    // Integer pair: 4-byte integer part, 2-byte decimal count, 2 unused bytes.
    function automatic logic [127:0] int_pair(input logic [31:0] i1, input logic [15:0] d1,
                                              input logic [31:0] i2, input logic [15:0] d2);
        int_pair = {i1, d1, 16'h0000, i2, d2, 16'h0000};                       // [R3]
    endfunction

    always_comb begin
        blk = '0;
        unique case (kind)
            FDB_KIND_LEVSP: begin
                if (is_float) begin
                    blk[127:64] = {16'h0000, level_flags[15:0], 16'h0000, level_flags[31:16]};
                end else begin
                    blk[127:64] = {level_flags[15:0], level_flags[31:16],
                                   setp_flags[7:0], 8'h00, setp_flags[15:8], 8'h00}; // [R1]
                end
            end
            FDB_KIND_AO12, FDB_KIND_AO34: begin
                if (is_float) begin
                    blk = {analog_output_flt[31:0], analog_output_flt[63:32],
                           analog_output_flt[95:64], analog_output_flt[127:96]}; // [R2]
                end else if (kind == FDB_KIND_AO12) begin
                    blk = int_pair(analog_output_int[31:0], analog_output_dec[15:0],
                                   analog_output_int[63:32], analog_output_dec[31:16]); // [R4]
                end else begin
                    blk = int_pair(analog_output_int[95:64], analog_output_dec[47:32],
                                   analog_output_int[127:96], analog_output_dec[63:48]); // [R4]
                end
            end
            default: blk = '0;
        endcase
    end

endmodule

// *** rtl/fdb_wr_seq.sv ***
/*
 * Emits a burst of consecutive register writes taken from the command
 * area, one 16-bit register per accepted handshake.
 * Assumes start is only raised while busy is low.
 */
`timescale 1ns/1ps
module fdb_wr_seq import fdb_pkg::*; (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic        ce,
    // Burst request
    input  wire logic        start,
    input  wire logic [2:0]  count,
    input  wire logic [15:0] addr,
    input  wire logic [95:0] data,
    output logic             busy,
    // Register write port
    output logic             wr_valid,
    input  wire logic        wr_ready,
    output logic      [15:0] wr_addr,
    output logic      [15:0] wr_data
);

    fdb_wr_state_e state_ff;
    logic [2:0]    left_ff;
    logic [95:0]   data_ff;
    logic [15:0]   addr_ff;
    logic          xfer;

    assign xfer     = ce && wr_valid && wr_ready;
    assign busy     = (state_ff == FDB_WR_SEND);
    assign wr_valid = busy;
    assign wr_addr  = addr_ff;
    assign wr_data  = data_ff[95:80];

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= FDB_WR_IDLE;
            left_ff  <= 3'h0;
        end else if (ce) begin
            unique case (state_ff)
                FDB_WR_IDLE: begin
                    if (start) begin
                        state_ff <= FDB_WR_SEND;
                        left_ff  <= count;                                  // [R6]
                    end
                end
                FDB_WR_SEND: begin
                    if (xfer) begin
                        left_ff <= left_ff - 3'h1;
                        if (left_ff == 3'h1) begin
                            state_ff <= FDB_WR_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Registers go out in ascending address, first register from bytes 4-5.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            addr_ff <= FDB_RST_ADDR;
            data_ff <= '0;
        end else if (ce) begin
            if (start && !busy) begin
                addr_ff <= addr;
                data_ff <= data;
            end else if (xfer) begin
                addr_ff <= addr_ff + 16'h0001;                              // [R7] [R8]
                data_ff <= {data_ff[79:0], 16'h0000};
            end
        end
    end

    property p_wr_step;
        @(posedge mclk) disable iff (!nrst)
        xfer && (left_ff != 3'h1) |=> wr_valid && (wr_addr == $past(wr_addr) + 16'h0001);
    endproperty
    AST_WR_STEP: assert property (p_wr_step) else $error("write address did not step"); // [R7]

    AST_WR_LAST: assert property (@(posedge mclk) disable iff (!nrst) // [R8]
        xfer && (left_ff == 3'h1) |=> !wr_valid)
        else $error("write burst overran its count");

    COV_WR_THREE: cover property (@(posedge mclk) disable iff (!nrst)
        start && !busy && (count == 3'h3));

endmodule

// *** rtl/fdb_cmd_port.sv ***
/*
 * Fieldbus cyclic data-block image and command-area interpreter.
 * Assumes the command area is driven by logic on mclk, so it is not
 * synchronised; the master keeps its side of the change protocol.
 */
// Summary of operation
// R1: Integer level/setpoint block: flags in bytes 0-7.
// R2: Float analog block: four values, MSB first.
// R3: Integer analog value: 4-byte int, 2-byte decimals.
// R4: Analog 1-2 and 3-4 in separate blocks.
// R5: Master changes command byte before repeating command.
// R6: Write command: count, address, up to six registers.
// R7: Float value spans two registers, count two.
// R8: Integer value: two registers plus decimals, count three.
// R9: Window command takes address, ignores count byte.
// R10: Read window always twelve consecutive registers.
// R11: Clear-reset command clears program-reset flag.
// R12: Operational command code alone in byte 0.
// R13: Unused command-area bytes are ignored.
// R14: Per-block format parameter selects integer or float.
// R15: Each command byte change executes exactly once.
`timescale 1ns/1ps
module fdb_cmd_port import fdb_pkg::*; #(
    parameter int NUM_BLOCKS = FDB_NUM_BLOCKS
) (
    // Clock, reset and enable
    input  wire logic                       mclk,
    input  wire logic                       nrst,
    input  wire logic                       ce,
    // Command area written by the master
    input  wire logic [127:0]               cmd_area,
    // Live instrument values
    input  wire logic [31:0]                level_flags,
    input  wire logic [15:0]                setp_flags,
    input  wire logic [127:0]               analog_output_flt,
    input  wire logic [127:0]               analog_output_int,
    input  wire logic [63:0]                analog_output_dec,
    // Per-block layout selection
    input  wire logic [NUM_BLOCKS-1:0]      blk_float,
    input  wire logic [2*NUM_BLOCKS-1:0]    blk_kind,
    // Cyclic image towards the master
    output logic      [128*NUM_BLOCKS-1:0]  image,
    // Register write port
    output logic                            wr_valid,
    input  wire logic                       wr_ready,
    output logic      [15:0]                wr_addr,
    output logic      [15:0]                wr_data,
    // Read window placement
    output logic                            win_load,
    output logic      [15:0]                win_base,
    output logic      [4:0]                 win_len,
    // Status and operational commands
    output logic                            prog_reset_clr,
    output logic                            op_valid,
    output logic      [7:0]                 op_code,
    output logic                            cmd_err
);

    // The image has no layouts beyond the twelve blocks a master can address.
    if (NUM_BLOCKS < 1 || NUM_BLOCKS > FDB_NUM_BLOCKS) begin : g_bad_blocks
        $error("NUM_BLOCKS out of range");
    end

    logic [7:0]                 cmd_byte;
    logic [7:0]                 cnt_byte;
    logic [15:0]                addr_field;
    logic [95:0]                data_field;
    logic [7:0]                 prev_cmd_ff;
    logic                       fire;
    logic                       wr_busy;
    logic                       wr_start;
    logic                       cnt_ok;
    logic [128*NUM_BLOCKS-1:0]  nxt_image;
    logic [128*NUM_BLOCKS-1:0]  image_ff;
    logic                       win_load_ff;
    logic [15:0]                win_base_ff;
    logic                       clr_ff;
    logic                       op_valid_ff;
    logic [7:0]                 op_code_ff;
    logic                       err_ff;

    assign cmd_byte   = cmd_area[FDB_CMD_MSB -: 8];
    assign cnt_byte   = cmd_area[FDB_CNT_MSB -: 8];
    assign addr_field = cmd_area[FDB_ADDR_MSB -: 16];
    assign data_field = cmd_area[FDB_DATA_MSB -: FDB_DATA_BITS];

    // A change seen while a write burst is still draining is held off, not
    // dropped: the previous byte is only updated when the change is acted on.
    assign fire     = ce && (cmd_byte != prev_cmd_ff) && !wr_busy;              // [R15]
    assign cnt_ok   = (cnt_byte != 8'h00) && (cnt_byte <= FDB_MAX_WR_REGS);
    assign wr_start = fire && (cmd_byte == FDB_CMD_WRITE) && cnt_ok;            // [R6]

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prev_cmd_ff <= FDB_RST_CMD;
        end else if (fire) begin
            prev_cmd_ff <= cmd_byte;                                            // [R15]
        end
    end

    fdb_wr_seq u_wr_seq (
        .mclk     (mclk),
        .nrst     (nrst),
        .ce       (ce),
        .start    (wr_start),
        .count    (cnt_byte[2:0]),
        .addr     (addr_field),
        .data     (data_field),
        .busy     (wr_busy),
        .wr_valid (wr_valid),
        .wr_ready (wr_ready),
        .wr_addr  (wr_addr),
        .wr_data  (wr_data)
    );

    // Window placement only looks at the address field.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            win_load_ff <= 1'b0;
            win_base_ff <= FDB_RST_ADDR;
        end else if (ce) begin
            win_load_ff <= 1'b0;
            if (fire && cmd_byte == FDB_CMD_WINDOW) begin
                win_load_ff <= 1'b1;
                win_base_ff <= addr_field;                                      // [R9]
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            clr_ff <= 1'b0;
        end else if (ce) begin
            clr_ff <= fire && (cmd_byte == FDB_CMD_CLR_RST);                    // [R11]
        end
    end

    // Any nonzero code that is not a port-level code passes on as an instrument command.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            op_valid_ff <= 1'b0;
            op_code_ff  <= FDB_RST_CMD;
        end else if (ce) begin
            op_valid_ff <= 1'b0;
            if (fire && cmd_byte != FDB_CMD_NONE && cmd_byte != FDB_CMD_WRITE &&
                cmd_byte != FDB_CMD_WINDOW && cmd_byte != FDB_CMD_CLR_RST) begin
                op_valid_ff <= 1'b1;                                            // [R12]
                op_code_ff  <= cmd_byte;                                        // [R13]
            end
        end
    end

    // A write with a count of zero or above six cannot be served.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            err_ff <= 1'b0;
        end else if (ce) begin
            err_ff <= fire && (cmd_byte == FDB_CMD_WRITE) && !cnt_ok;
        end
    end

    genvar b;
    generate
        for (b = 0; b < NUM_BLOCKS; b++) begin : g_blk
            fdb_blk_pack u_pack (
                .kind              (fdb_kind_e'(blk_kind[2*b +: 2])),
                .is_float          (blk_float[b]),                              // [R14]
                .level_flags       (level_flags),
                .setp_flags        (setp_flags),
                .analog_output_flt (analog_output_flt),
                .analog_output_int (analog_output_int),
                .analog_output_dec (analog_output_dec),
                .blk               (nxt_image[128*(NUM_BLOCKS-1-b) +: 128])
            );
        end
    endgenerate

    // The whole image is refreshed together so the master never sees a torn block.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            image_ff <= '0;
        end else if (ce) begin
            image_ff <= nxt_image;                                              // [R14]
        end
    end

    assign image          = image_ff;
    assign win_load       = win_load_ff;
    assign win_base       = win_base_ff;
    assign win_len        = FDB_WIN_REGS;                                       // [R10]
    assign prog_reset_clr = clr_ff;
    assign op_valid       = op_valid_ff;
    assign op_code        = op_code_ff;
    assign cmd_err        = err_ff;

    localparam int TOP = 128*NUM_BLOCKS-1;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    AST_WR_START: assert property ( // [R6]
        wr_start |=> wr_valid && (wr_addr == $past(addr_field))
                     && (wr_data == $past(data_field[95:80])))
        else $error("write burst did not start at the given address");

    AST_WIN: assert property ( // [R9]
        fire && cmd_byte == FDB_CMD_WINDOW
        |=> win_load && (win_base == $past(addr_field)) ##1 !win_load)
        else $error("window base not loaded");

    AST_WIN_LEN: assert property ( // [R10]
        win_load |-> win_len == 5'h0C)
        else $error("window length is not twelve");

    AST_CLR: assert property ( // [R11]
        fire && cmd_byte == FDB_CMD_CLR_RST |=> prog_reset_clr ##1 !prog_reset_clr)
        else $error("clear-reset pulse wrong");

    AST_OP: assert property ( // [R12]
        op_valid |-> $past(fire) && (op_code == $past(cmd_byte)) && !win_load && !prog_reset_clr)
        else $error("operational command not from a change");

    AST_ONCE: assert property ( // [R15]
        ce && !fire |=> !op_valid && !win_load && !prog_reset_clr && !cmd_err)
        else $error("action without a command change");

    AST_NO_REPEAT: assert property ( // [R15]
        fire ##1 (ce && $stable(cmd_byte)) |-> !fire)
        else $error("unchanged command byte fired again");

    AST_LEVSP: assert property ( // [R1]
        ce && blk_kind[1:0] == 2'(FDB_KIND_LEVSP) && !blk_float[0] |=>
        image[TOP -: 64] == {$past(level_flags[15:0]), $past(level_flags[31:16]),
                             $past(setp_flags[7:0]), 8'h00, $past(setp_flags[15:8]), 8'h00}
        && image[TOP-64 -: 64] == 64'h0000_0000_0000_0000)
        else $error("level/setpoint block misplaced");

    AST_AOFLT: assert property ( // [R2]
        ce && blk_kind[1:0] == 2'(FDB_KIND_AO12) && blk_float[0] |=>
        image[TOP -: 32] == $past(analog_output_flt[31:0])
        && image[TOP-96 -: 32] == $past(analog_output_flt[127:96]))
        else $error("float analog block misplaced");

    AST_AOINT: assert property ( // [R3] [R4]
        ce && blk_kind[1:0] == 2'(FDB_KIND_AO34) && !blk_float[0] |=>
        image[TOP -: 64] == {$past(analog_output_int[95:64]),
                             $past(analog_output_dec[47:32]), 16'h0000})
        else $error("integer analog block misplaced");

    // A refused write must not start a burst, or the register file gets garbage.
    AST_WR_ERR: assert property ( // [R6]
        fire && cmd_byte == FDB_CMD_WRITE && (cnt_byte == 8'h00 || cnt_byte > 8'h06)
        |=> cmd_err && !wr_valid)
        else $error("bad write count not refused");

    // A stalled register must not move, or the master would store a torn value.
    AST_WR_HOLD: assert property ( // [R6]
        wr_valid && !(ce && wr_ready) |=> wr_valid && $stable(wr_addr) && $stable(wr_data))
        else $error("write request changed before it was taken");

    // With the clock enable low no command may act and nothing held may move.
    AST_FREEZE: assert property ( // [R15]
        !ce |=> $stable(image) && $stable(win_base) && $stable(op_code) && $stable(wr_addr))
        else $error("state moved while the clock enable was low");

    COV_WRITE: cover property (wr_start ##[1:12] !wr_valid);
    COV_WINDOW: cover property (win_load);
    COV_OP: cover property (op_valid ##[1:20] op_valid);

endmodule

// *** verif/fdb_master_model.sv ***
/*
 * Behavioural fieldbus master: owns the command area and the ready
 * line of the register write port, and can accept writes slowly.
 * Assumes one clock shared with the block under test.
 */
`timescale 1ns/1ps
module fdb_master_model (
    // Clock
    input  wire logic         mclk,
    // Command area and write acceptance
    output logic      [127:0] cmd_area,
    output logic              wr_ready
);
    logic slow;

    initial begin
        cmd_area = '0;
        wr_ready = 1'b0;
        slow     = 1'b0;
    end

    // A slow master accepts every other cycle, so bursts see stalls.
    always @(negedge mclk) begin
        wr_ready <= slow ? ~wr_ready : 1'b1;
    end

    task automatic issue(input logic [7:0] c, input logic [7:0] n,
                         input logic [15:0] a, input logic [95:0] d);
        if (cmd_area[127:120] === c && c !== 8'h00) begin
            @(negedge mclk);
            cmd_area[127:120] = 8'h00;
        end
        @(negedge mclk);
        cmd_area = {c, n, a, d};
    endtask
endmodule

// *** verif/fdb_cmd_port_tb_top.sv ***
/*
 * Self-checking bench for the data-block image and command port.
 * Assumes the master model of its own file and four blocks of mixed layout.
 */
`timescale 1ns/1ps
module fdb_cmd_port_tb_top;
    import fdb_pkg::*;
    localparam int NB = 4;

    logic              mclk;
    logic              nrst;
    logic              ce;
    logic [127:0]      cmd_area;
    logic [31:0]       level_flags;
    logic [15:0]       setp_flags;
    logic [127:0]      analog_output_flt;
    logic [127:0]      analog_output_int;
    logic [63:0]       analog_output_dec;
    logic [NB-1:0]     blk_float;
    logic [2*NB-1:0]   blk_kind;
    logic [128*NB-1:0] image;
    logic              wr_valid;
    logic              wr_ready;
    logic [15:0]       wr_addr;
    logic [15:0]       wr_data;
    logic              win_load;
    logic [15:0]       win_base;
    logic [4:0]        win_len;
    logic              prog_reset_clr;
    logic              op_valid;
    logic [7:0]        op_code;
    logic              cmd_err;
    int                num_errors;
    int                comparisons;
    int                n_win;
    int                n_clr;
    int                n_op;
    int                n_err;
    logic [31:0]       wq[$];

    fdb_master_model mst (.mclk(mclk), .cmd_area(cmd_area), .wr_ready(wr_ready));

    fdb_cmd_port #(.NUM_BLOCKS(NB)) DUT (
        .mclk(mclk), .nrst(nrst), .ce(ce), .cmd_area(cmd_area),
        .level_flags(level_flags), .setp_flags(setp_flags),
        .analog_output_flt(analog_output_flt), .analog_output_int(analog_output_int),
        .analog_output_dec(analog_output_dec), .blk_float(blk_float),
        .blk_kind(blk_kind), .image(image), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .wr_addr(wr_addr), .wr_data(wr_data), .win_load(win_load), .win_base(win_base),
        .win_len(win_len), .prog_reset_clr(prog_reset_clr), .op_valid(op_valid),
        .op_code(op_code), .cmd_err(cmd_err));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // Pulses are counted per edge so a stuck or repeated pulse shows up.
    always @(posedge mclk) begin
        n_win <= n_win + int'(win_load);
        n_clr <= n_clr + int'(prog_reset_clr);
        n_op  <= n_op + int'(op_valid);
        n_err <= n_err + int'(cmd_err);
        if (wr_valid === 1'b1 && wr_ready === 1'b1 && ce === 1'b1) begin
            wq.push_back({wr_addr, wr_data});
        end
    end

    task automatic check(input string name, input logic [127:0] seen, input logic [127:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic clr();
        @(negedge mclk);
        n_win = 0;
        n_clr = 0;
        n_op  = 0;
        n_err = 0;
        wq    = {};
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic final_report();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic t_image();
        logic [127:0] e_flt;
        logic [127:0] e_a12;
        logic [127:0] e_a34;
        e_flt = {analog_output_flt[31:0], analog_output_flt[63:32],
                 analog_output_flt[95:64], analog_output_flt[127:96]};
        e_a12 = {analog_output_int[31:0], analog_output_dec[15:0], 16'h0,
                 analog_output_int[63:32], analog_output_dec[31:16], 16'h0};
        e_a34 = {analog_output_int[95:64], analog_output_dec[47:32], 16'h0,
                 analog_output_int[127:96], analog_output_dec[63:48], 16'h0};
        wait_cyc(3);
        check("blk0", image[511 -: 128], {level_flags[15:0], level_flags[31:16],
              setp_flags[7:0], 8'h00, setp_flags[15:8], 8'h00, 64'h0});
        check("blk1", image[383 -: 128], e_a12);
        check("blk2", image[255 -: 128], e_a34);
        check("blk3", image[127 -: 128], e_flt);
        // Move the float and analog layouts into block 0 and show the float level layout
        // and the unused kind, so every decoded layout is seen at least once.
        blk_float = 4'b0011;
        blk_kind  = 8'hB1;
        wait_cyc(3);
        check("blk0 float", image[511 -: 128], e_flt);
        check("blk1 float", image[383 -: 128], {16'h0, level_flags[15:0], 16'h0,
              level_flags[31:16], 64'h0});
        check("blk2 unused", image[255 -: 128], 128'h0);
        check("blk3 a34", image[127 -: 128], e_a34);
        blk_float = 4'b0010;
        blk_kind  = 8'hB2;
        wait_cyc(3);
        check("blk0 a34", image[511 -: 128], e_a34);
    endtask

    task automatic t_window();
        clr();
        mst.issue(FDB_CMD_WINDOW, 8'h55, 16'hAC2A, {6{16'hA5C3}});
        wait_cyc(5);
        check("win_load count", 128'(n_win), 128'(1));
        check("win_base", 128'(win_base), 128'(16'hAC2A));
        check("win_len", 128'(win_len), 128'(5'h0C));
        check("window writes", 128'(wq.size()), 128'(0));
    endtask

    task automatic t_write(input logic [7:0] n, input logic [15:0] a, input logic [95:0] d);
        int i;
        clr();
        mst.issue(FDB_CMD_WRITE, n, a, d);
        for (i = 0; i < 60 && wq.size() < int'(n); i++) begin
            wait_cyc(1);
        end
        wait_cyc(6);
        check("write count", 128'(wq.size()), 128'(n));
        for (i = 0; i < int'(n) && i < wq.size(); i++) begin
            check("write", 128'(wq[i]), 128'({a + 16'(i), d[95 - 16*i -: 16]}));
        end
    endtask

    task automatic t_bad_count();
        clr();
        mst.issue(FDB_CMD_WRITE, 8'h00, 16'h1000, '0);
        wait_cyc(4);
        mst.issue(FDB_CMD_WRITE, 8'h07, 16'h1000, '1);
        wait_cyc(6);
        check("cmd_err count", 128'(n_err), 128'(2));
        check("bad writes", 128'(wq.size()), 128'(0));
    endtask

    task automatic t_clear_reset();
        clr();
        mst.issue(FDB_CMD_CLR_RST, 8'hFF, 16'hFFFF, '1);
        wait_cyc(8);
        check("clear count", 128'(n_clr), 128'(1));
    endtask

    task automatic t_ops();
        logic [7:0] codes[3];
        int i;
        codes = '{8'h01, 8'h02, 8'h03};
        clr();
        ce = 1'b0;
        mst.issue(8'h05, 8'h00, 16'h0000, '0);
        wait_cyc(3);
        check("op with ce low", 128'(n_op), 128'(0));
        ce = 1'b1;
        wait_cyc(3);
        check("op after ce", 128'(n_op), 128'(1));
        check("op_code", 128'(op_code), 128'(8'h05));
        for (i = 0; i < 3; i++) begin
            clr();
            mst.issue(codes[i], 8'hAA, 16'h5555, {6{16'h33CC}});
            wait_cyc(4);
            check("op count", 128'(n_op), 128'(1));
            check("op_code", 128'(op_code), 128'(codes[i]));
        end
    endtask

    initial begin
        num_errors = 0;
        comparisons = 0;
        nrst = 1'b0;
        ce = 1'b1;
        level_flags = 32'hA1B2_C3D4;
        setp_flags = 16'h5E6F;
        analog_output_flt = 128'h1111_2222_3333_4444_5555_6666_7777_8888;
        analog_output_int = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
        analog_output_dec = 64'h0001_0002_0003_0004;
        blk_float = 4'b1000;
        blk_kind = 8'h64;
        wait_cyc(6);
        check("win_len in reset", 128'(win_len), 128'(5'h0C));
        check("image in reset", image[127:0], 128'h0);
        nrst = 1'b1;
        t_image();
        t_window();
        mst.slow = 1'b1;
        t_write(8'h02, 16'hB3CA, {32'h42F7_0000, {4{16'hDEAD}}});
        t_write(8'h03, 16'hA4B9, {48'h0000_303E_0002, {3{16'hBEEF}}});
        mst.slow = 1'b0;
        t_write(8'h06, 16'hFFFC, 96'h0102_0304_0506_0708_090A_0B0C);
        t_bad_count();
        t_clear_reset();
        t_ops();
        final_report();
    end

    // The whole run needs well under a thousand cycles.
    initial begin
        #(5 * 5000);
        num_errors++;
        final_report();
    end
endmodule
